// ==== hw/pmo_pkg.sv ====
// constants, types and register map of the power-mode output pin block
package pmo_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int          ADDR_W   = 10;       // byte address on the bus
    localparam int          DATA_W   = 32;
    localparam int          REG_W    = 8;        // documented register width
    localparam int          NIB_W    = 4;        // one nibble per pin
    localparam int          NUM_PINS = 4;

    // ****************************************************************
    // register indices; byte address is four times the index
    // ****************************************************************
    localparam logic [7:0]  IDX_HDD_AUX  = 8'hab;
    localparam logic [7:0]  IDX_FDD_PIO  = 8'hac;
    localparam logic [7:0]  IDX_PIN_STAT = 8'hb8; // read-only pin and mode view

    localparam logic [ADDR_W-1:0] ADDR_HDD_AUX  = {IDX_HDD_AUX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FDD_PIO  = {IDX_FDD_PIO, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PIN_STAT = {IDX_PIN_STAT, 2'b00};

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [REG_W-1:0] RST_HDD_AUX = 8'h00;
    localparam logic [REG_W-1:0] RST_FDD_PIO = 8'h00;

    // power-on pin levels: hdd low, aux high, pio low, floppy low
    localparam logic RST_HDD_PIN    = 1'b0;
    localparam logic RST_AUX_PIN    = 1'b1;
    localparam logic RST_PIO_PIN    = 1'b0;
    localparam logic RST_FLOPPY_PIN = 1'b0;

    // ****************************************************************
    // field layout
    // ****************************************************************
    // nibble slot order in {fdd_pio, hdd_aux}: aux, hdd, floppy, pio
    localparam int SLOT_AUX    = 0;
    localparam int SLOT_HDD    = 1;
    localparam int SLOT_FLOPPY = 2;
    localparam int SLOT_PIO    = 3;

    localparam int NIB_LO_LSB = 0;   // bits 3..0
    localparam int NIB_HI_LSB = 4;   // bits 7..4

    // bit inside a nibble for each mode
    localparam int BIT_RUN     = 0;
    localparam int BIT_DOZE    = 1;
    localparam int BIT_SLEEP   = 2;
    localparam int BIT_SUSPEND = 3;

    // status register layout
    localparam int STAT_PIN_LSB  = 0;   // four pin levels in slot order
    localparam int STAT_MODE_LSB = 4;   // current mode code, three bits
    localparam int MODE_W        = 3;

    localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [MODE_W-1:0] {
        PMO_HS_PLL,
        PMO_LS_PLL,
        PMO_DOZE,
        PMO_SLEEP,
        PMO_SUSPEND
    } pmo_mode_e;

    typedef struct packed {
        logic pio;
        logic floppy;
        logic hdd;
        logic aux;
    } pmo_pins_s;

    typedef struct packed {
        logic hdd;
        logic floppy;
        logic pio;
    } pmo_expiry_s;

endpackage

// ==== hw/pmo_mode_sel.sv ====
// picks one pin level out of a four-bit mode nibble
`timescale 1ns/1ps

module pmo_mode_sel (
    input  wire logic [pmo_pkg::NIB_W-1:0] nibble,
    input  wire pmo_pkg::pmo_mode_e        mode,
    input  wire logic                      invert,
    output logic                           level
);

    logic sel;

    // both pll modes share the run bit; unknown codes fall back to run
    always_comb begin
        sel = nibble[pmo_pkg::BIT_RUN];
        unique case (mode)
            pmo_pkg::PMO_HS_PLL,
            pmo_pkg::PMO_LS_PLL:  sel = nibble[pmo_pkg::BIT_RUN];
            pmo_pkg::PMO_DOZE:    sel = nibble[pmo_pkg::BIT_DOZE];
            pmo_pkg::PMO_SLEEP:   sel = nibble[pmo_pkg::BIT_SLEEP];
            pmo_pkg::PMO_SUSPEND: sel = nibble[pmo_pkg::BIT_SUSPEND];
            default:              sel = nibble[pmo_pkg::BIT_RUN];
        endcase
        level = sel ^ invert;   // aux pin: a zero bit drives high
    end

endmodule

// ==== hw/pmo_top.sv ====
// power-mode output pin controller with avalon-mm register slave
//
// Behaviour
// - hdd pin follows upper nibble of first register, bit by current mode.
// - aux pin is inverse of lower nibble bit of first register, by mode.
// - hdd pin low after reset and low whenever its selected bit is zero.
// - aux pin high after reset and high whenever its selected bit is zero.
// - hdd timer expiry clears upper nibble of first register.
// - pio pin follows upper nibble of second register, bit by mode.
// - floppy pin follows lower nibble of second register, bit by mode.
// - floppy and pio pins low after reset and when selected bit zero.
// - pio timer expiry clears upper nibble of second register.
// - floppy timer expiry clears lower nibble of second register.
`timescale 1ns/1ps

module pmo_top (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // avalon-mm slave
    input  wire logic [pmo_pkg::ADDR_W-1:0]   address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [pmo_pkg::DATA_W-1:0]   writedata,
    input  wire logic [3:0]                   byteenable,
    output logic      [pmo_pkg::DATA_W-1:0]   readdata,
    output logic                              waitrequest,
    // power management state
    input  wire pmo_pkg::pmo_mode_e           mode,
    input  wire logic                         hdd_timer_expired,
    input  wire logic                         floppy_timer_expired,
    input  wire logic                         pio_timer_expired,
    // power pins
    output logic                              hdd_power_out,
    output logic                              aux_inverted_power_out,
    output logic                              pio_power_out,
    output logic                              floppy_power_out
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    localparam int NIB_HI_MSB = pmo_pkg::NIB_HI_LSB + pmo_pkg::NIB_W - 1;
    localparam int NIB_LO_MSB = pmo_pkg::NIB_LO_LSB + pmo_pkg::NIB_W - 1;
    localparam int STAT_MODE_MSB = pmo_pkg::STAT_MODE_LSB + pmo_pkg::MODE_W - 1;
    localparam int STAT_PIN_MSB  = pmo_pkg::STAT_PIN_LSB + pmo_pkg::NUM_PINS - 1;

    logic                              ack_q;
    logic                              ack_d;
    logic [pmo_pkg::DATA_W-1:0]        rdata_q;
    logic [pmo_pkg::DATA_W-1:0]        rdata_d;

    logic [pmo_pkg::REG_W-1:0]         hdd_aux_q;
    logic [pmo_pkg::REG_W-1:0]         hdd_aux_d;
    logic [pmo_pkg::REG_W-1:0]         fdd_pio_q;
    logic [pmo_pkg::REG_W-1:0]         fdd_pio_d;

    pmo_pkg::pmo_pins_s                pins_q;
    pmo_pkg::pmo_pins_s                pins_d;
    pmo_pkg::pmo_expiry_s              expiry;

    logic [pmo_pkg::NUM_PINS-1:0]      sel_level;
    logic [2*pmo_pkg::REG_W-1:0]       nibbles;
    logic                              req;
    logic                              wr_fire;
    logic                              wr_lane0;
    logic                              hit_hdd_aux;
    logic                              hit_fdd_pio;
    logic                              hit_stat;

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    // every access takes one wait cycle; the registered answer keeps
    // readdata off the combinational decode path
    assign req         = read | write;
    assign waitrequest = req & ~ack_q;
    assign readdata    = rdata_q;
    assign wr_fire     = write & ack_q;
    assign wr_lane0    = byteenable[0];   // registers live in byte lane 0

    assign hit_hdd_aux = (address == pmo_pkg::ADDR_HDD_AUX);
    assign hit_fdd_pio = (address == pmo_pkg::ADDR_FDD_PIO);
    assign hit_stat    = (address == pmo_pkg::ADDR_PIN_STAT);

    // ack rises one cycle after the request and drops after it is taken
    always_comb begin
        ack_d   = req & ~ack_q;
        rdata_d = rdata_q;
        if (read & ~ack_q) begin
            rdata_d = pmo_pkg::RD_ZERO;   // unmapped reads return zero
            if (hit_hdd_aux) begin
                rdata_d[pmo_pkg::REG_W-1:0] = hdd_aux_q;
            end else if (hit_fdd_pio) begin
                rdata_d[pmo_pkg::REG_W-1:0] = fdd_pio_q;
            end else if (hit_stat) begin
                rdata_d[STAT_PIN_MSB:pmo_pkg::STAT_PIN_LSB]   = pins_q;
                rdata_d[STAT_MODE_MSB:pmo_pkg::STAT_MODE_LSB] = mode;
            end
        end
    end

    // bus handshake registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= pmo_pkg::RD_ZERO;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // output control registers
    // ****************************************************************
    assign expiry.hdd    = hdd_timer_expired;
    assign expiry.floppy = floppy_timer_expired;
    assign expiry.pio    = pio_timer_expired;

    // software write first, then timer clears on top: an expiry in the
    // same cycle as a write wins so a powered-down drive stays off
    always_comb begin
        hdd_aux_d = hdd_aux_q;
        fdd_pio_d = fdd_pio_q;
        if (wr_fire && wr_lane0 && hit_hdd_aux) begin
            hdd_aux_d = writedata[pmo_pkg::REG_W-1:0];
        end
        if (wr_fire && wr_lane0 && hit_fdd_pio) begin
            fdd_pio_d = writedata[pmo_pkg::REG_W-1:0];
        end
        if (expiry.hdd) begin
            hdd_aux_d[NIB_HI_MSB:pmo_pkg::NIB_HI_LSB] = pmo_pkg::NIB_ZERO;
        end
        if (expiry.pio) begin
            fdd_pio_d[NIB_HI_MSB:pmo_pkg::NIB_HI_LSB] = pmo_pkg::NIB_ZERO;
        end
        if (expiry.floppy) begin
            fdd_pio_d[NIB_LO_MSB:pmo_pkg::NIB_LO_LSB] = pmo_pkg::NIB_ZERO;
        end
    end

    // control register storage; timers are trusted to be off when unused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hdd_aux_q <= pmo_pkg::RST_HDD_AUX;
            fdd_pio_q <= pmo_pkg::RST_FDD_PIO;
        end else begin
            hdd_aux_q <= hdd_aux_d;
            fdd_pio_q <= fdd_pio_d;
        end
    end

    // ****************************************************************
    // per-pin mode selection
    // ****************************************************************
    // slot order: aux, hdd, floppy, pio; only the aux slot inverts
    assign nibbles = {fdd_pio_q, hdd_aux_q};

    genvar g;
    generate
        for (g = 0; g < pmo_pkg::NUM_PINS; g = g + 1) begin : g_pin
            pmo_mode_sel u_sel (
                .nibble (nibbles[g*pmo_pkg::NIB_W +: pmo_pkg::NIB_W]),
                .mode   (mode),
                .invert (g == pmo_pkg::SLOT_AUX),
                .level  (sel_level[g])
            );
        end
    endgenerate

    // ****************************************************************
    // pin registers
    // ****************************************************************
    // levels follow the stored bits, so a mode change shows one clock later;
    // a write or a timer clear reaches the pins the clock after that
    always_comb begin
        pins_d.hdd    = sel_level[pmo_pkg::SLOT_HDD];
        pins_d.aux    = sel_level[pmo_pkg::SLOT_AUX];
        pins_d.pio    = sel_level[pmo_pkg::SLOT_PIO];
        pins_d.floppy = sel_level[pmo_pkg::SLOT_FLOPPY];
    end

    // registered pins avoid glitches on external power switches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_q.hdd    <= pmo_pkg::RST_HDD_PIN;
            pins_q.aux    <= pmo_pkg::RST_AUX_PIN;
            pins_q.pio    <= pmo_pkg::RST_PIO_PIN;
            pins_q.floppy <= pmo_pkg::RST_FLOPPY_PIN;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign hdd_power_out          = pins_q.hdd;
    assign aux_inverted_power_out = pins_q.aux;
    assign pio_power_out          = pins_q.pio;
    assign floppy_power_out       = pins_q.floppy;

endmodule

// ==== dv/pmo_switch_model.sv ====
// behavioural model of the external peripheral power switches
`timescale 1ns/1ps

module pmo_switch_model (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire pmo_pkg::pmo_pins_s pins,
    output pmo_pkg::pmo_pins_s      rail
);
    // rail follows its enable one clock late; the aux switch is active low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rail <= '0;
        end else begin
            rail <= {pins.pio, pins.floppy, pins.hdd, ~pins.aux};
        end
    end
endmodule

// ==== dv/pmo_properties.sv ====
// concurrent checks on the ports of the power-mode output pin block
`timescale 1ns/1ps

module pmo_properties (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic [pmo_pkg::ADDR_W-1:0] address,
    input wire logic                       read,
    input wire logic                       write,
    input wire logic [pmo_pkg::DATA_W-1:0] readdata,
    input wire logic                       waitrequest,
    input wire pmo_pkg::pmo_mode_e         mode,
    input wire logic                       hdd_timer_expired,
    input wire logic                       floppy_timer_expired,
    input wire logic                       pio_timer_expired,
    input wire logic                       hdd_power_out,
    input wire logic                       aux_inverted_power_out,
    input wire logic                       pio_power_out,
    input wire logic                       floppy_power_out
);
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_wait_one_cycle: assert property (
        (read || write) && waitrequest |=> !waitrequest) else $error("wait too long");
    a_rdata_hold: assert property (
        !(read && waitrequest) |=> $stable(readdata)) else $error("readdata moved");
    a_reset_levels: assert property (
        $rose(rst_n) |-> !hdd_power_out && aux_inverted_power_out && !pio_power_out
        && !floppy_power_out) else $error("bad power-on pin levels");
    a_hdd_expiry_off: assert property (
        hdd_timer_expired |-> ##2 !hdd_power_out) else $error("hdd pin not off");
    a_pio_expiry_off: assert property (
        pio_timer_expired |-> ##2 !pio_power_out) else $error("pio pin not off");
    a_floppy_expiry_off: assert property (
        floppy_timer_expired |-> ##2 !floppy_power_out) else $error("floppy pin not off");
    // pins may move only after a write, an expiry or a mode change
    a_pins_idle_stable: assert property (
        !write && !hdd_timer_expired && !floppy_timer_expired && !pio_timer_expired
        && !$past(write) && !$past(hdd_timer_expired) && !$past(floppy_timer_expired)
        && !$past(pio_timer_expired)
        && $stable(mode) |=> $stable({hdd_power_out, aux_inverted_power_out,
        pio_power_out, floppy_power_out})) else $error("pins moved without cause");
    a_status_pin_view: assert property (
        read && waitrequest && address == pmo_pkg::ADDR_PIN_STAT |=> readdata[3:0] ==
        $past({pio_power_out, floppy_power_out, hdd_power_out, aux_inverted_power_out}))
        else $error("status pin view wrong");

    c_expiry: cover property (hdd_timer_expired);
    c_read_done: cover property (read && !waitrequest);
    c_suspend_on: cover property (mode == pmo_pkg::PMO_SUSPEND && hdd_power_out);
endmodule

bind pmo_top pmo_properties i_props (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .mode(mode), .hdd_timer_expired(hdd_timer_expired),
    .floppy_timer_expired(floppy_timer_expired), .pio_timer_expired(pio_timer_expired),
    .hdd_power_out(hdd_power_out), .aux_inverted_power_out(aux_inverted_power_out),
    .pio_power_out(pio_power_out), .floppy_power_out(floppy_power_out));

// ==== dv/pmo_top_test.sv ====
// self-checking testbench of the power-mode output pin block
`timescale 1ns/1ps

module pmo_top_test;
    logic                       clk         = 1'b0;
    logic                       rst_n       = 1'b0;
    logic [pmo_pkg::ADDR_W-1:0] address     = '0;
    logic                       read        = 1'b0;
    logic                       write       = 1'b0;
    logic [pmo_pkg::DATA_W-1:0] writedata   = '0;
    logic [3:0]                 byteenable  = 4'h1;
    logic [pmo_pkg::DATA_W-1:0] readdata;
    logic                       waitrequest;
    logic [pmo_pkg::DATA_W-1:0] v;
    pmo_pkg::pmo_mode_e         mode        = pmo_pkg::PMO_HS_PLL;
    pmo_pkg::pmo_expiry_s       exp_q       = '0;
    pmo_pkg::pmo_pins_s         pins;
    pmo_pkg::pmo_pins_s         rail;
    int                         fail_count  = 0;
    int                         total_checks = 0;
    int                         cycles      = 0;

    always #12.5 clk = ~clk;

    pmo_top i_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .mode(mode),
        .hdd_timer_expired(exp_q.hdd), .floppy_timer_expired(exp_q.floppy),
        .pio_timer_expired(exp_q.pio), .hdd_power_out(pins.hdd),
        .aux_inverted_power_out(pins.aux), .pio_power_out(pins.pio),
        .floppy_power_out(pins.floppy));
    pmo_switch_model i_sw (.clk(clk), .rst_n(rst_n), .pins(pins), .rail(rail));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        total_checks++;
        if (seen !== ex) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // one avalon cycle; strobes drop only at the rising edge that sees waitrequest
    // low; the global hang guard is the only way out of a stuck wait
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        byteenable <= be;
        writedata <= {24'h00_0000, d};
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        v = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic set_mode(input int m);
        @(posedge clk) mode <= pmo_pkg::pmo_mode_e'(m);
        @(posedge clk);
        @(negedge clk);
    endtask

    // run modes share bit 0, then doze, sleep, suspend
    task automatic pins_chk(input logic [7:0] r1, input logic [7:0] r2);
        int b;
        b = (mode > pmo_pkg::PMO_LS_PLL && mode <= pmo_pkg::PMO_SUSPEND) ? int'(mode) - 1 : 0;
        check("pins", pins, {r2[4+b], r2[b], r1[4+b], ~r1[b]});
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        check("pins at reset", pins, 4'h1);
        bus(1'b0, pmo_pkg::ADDR_HDD_AUX, 8'h00, 4'hf);
        check("hdd_aux reset", v, 32'h0000_0000);
        bus(1'b0, pmo_pkg::ADDR_FDD_PIO, 8'h00, 4'hf);
        check("fdd_pio reset", v, 32'h0000_0000);
    endtask

    // timers stay low here, as software must while pins serve other loads
    task automatic t_modes();
        logic [7:0] pats [5] = '{8'h00, 8'hff, 8'h5a, 8'h96, 8'hc3};
        foreach (pats[i]) begin
            bus(1'b1, pmo_pkg::ADDR_HDD_AUX, pats[i], 4'h1);
            bus(1'b1, pmo_pkg::ADDR_FDD_PIO, ~pats[i], 4'h1);
            bus(1'b0, pmo_pkg::ADDR_HDD_AUX, 8'h00, 4'hf);
            check("hdd_aux readback", v, {24'h00_0000, pats[i]});
            for (int m = 0; m < 5; m++) begin
                set_mode(m);
                pins_chk(pats[i], ~pats[i]);
            end
        end
    endtask

    // one pulse per timer: hdd, floppy, pio in turn
    task automatic t_expiry();
        logic [7:0] r1;
        logic [7:0] r2;
        set_mode(3);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, pmo_pkg::ADDR_HDD_AUX, 8'hff, 4'h1);
            bus(1'b1, pmo_pkg::ADDR_FDD_PIO, 8'hff, 4'h1);
            @(posedge clk) exp_q <= 3'b100 >> k;
            @(posedge clk) exp_q <= '0;
            r1 = (k == 0) ? 8'h0f : 8'hff;
            r2 = (k == 1) ? 8'hf0 : (k == 2) ? 8'h0f : 8'hff;
            bus(1'b0, pmo_pkg::ADDR_HDD_AUX, 8'h00, 4'hf);
            check("hdd_aux after expiry", v, {24'h00_0000, r1});
            bus(1'b0, pmo_pkg::ADDR_FDD_PIO, 8'h00, 4'hf);
            check("fdd_pio after expiry", v, {24'h00_0000, r2});
            pins_chk(r1, r2);
            check("hdd rail", rail.hdd, k != 0);
        end
    endtask

    // unmapped place, masked write and read-only status view
    task automatic t_misc();
        bus(1'b1, 10'h000, 8'hff, 4'h1);
        bus(1'b0, 10'h000, 8'h00, 4'hf);
        check("unmapped read", v, 32'h0000_0000);
        bus(1'b1, pmo_pkg::ADDR_HDD_AUX, 8'h00, 4'h0);
        bus(1'b1, pmo_pkg::ADDR_PIN_STAT, 8'hff, 4'h1);
        bus(1'b0, pmo_pkg::ADDR_HDD_AUX, 8'h00, 4'hf);
        check("masked write", v, 32'h0000_00ff);
        bus(1'b0, pmo_pkg::ADDR_PIN_STAT, 8'h00, 4'hf);
        check("status view", v, 32'h0000_0036);
    endtask

    // hang guard, well above the couple of hundred cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        t_reset();
        t_modes();
        t_expiry();
        t_misc();
        conclude();
    end
endmodule
